/* bench/rol_loader_tb.sv */
// Bench for the option loader: fills the option area, resets, checks the download.
// Assumes rol_params.svh on the include path; the bench drives every port itself.
`timescale 1ns/10ps
`include "rol_params.svh"

module rol_loader_tb;
	logic        mclk = 1'b0;
	logic        reset_n = 1'b0;
	logic        brownout_n = 1'b1;
	logic [12:0] reg_addr = 13'h0000;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [7:0]  reg_rdata;
	logic [15:0] pull_up_en;
	logic [15:0] pull_down_en;
	logic [1:0]  osc_cap_sel;
	logic        wdt_hardlock;
	logic        ext_clk_on_out_pin;
	logic        clk_mon_reset_en;
	logic        port_force_input;
	logic        options_valid;
	logic [7:0]  rdv;
	logic [7:0]  img [32];
	int          err_count = 0;
	int          checked = 0;

	always #10 mclk = ~mclk;

	rol_loader i_rol_loader (.mclk(mclk), .reset_n(reset_n), .brownout_n(brownout_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
		.osc_cap_sel(osc_cap_sel), .wdt_hardlock(wdt_hardlock),
		.ext_clk_on_out_pin(ext_clk_on_out_pin), .clk_mon_reset_en(clk_mon_reset_en),
		.port_force_input(port_force_input), .options_valid(options_valid));

	// ==========================================================
	// Access tasks
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp)
		begin
			err_count++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	task wr(input logic [12:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	task rd(input logic [12:0] a, output logic [7:0] d);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	task chk_held;
		chk({15'h0, port_force_input}, 16'h1);
		chk({15'h0, options_valid}, 16'h0);
		chk(pull_up_en | pull_down_en, 16'h0);
	endtask

	// After a release: check the hold-off, then wait for done
	task settle;
		int n;
		n = 0;
		repeat (100) @(posedge mclk);
		#1 chk_held();
		while (options_valid !== 1'b1 && n < 400)
		begin
			@(posedge mclk);
			n++;
		end
		#1 chk({15'h0, options_valid}, 16'h1);
	endtask

	// Low pulse on reset or brown-out, then settle
	task pulse(input bit bo);
		@(posedge mclk);
		if (bo) brownout_n <= 1'b0;
		else reset_n <= 1'b0;
		repeat (8) @(posedge mclk);
		#1 chk_held();
		@(posedge mclk);
		reset_n <= 1'b1;
		brownout_n <= 1'b1;
		settle();
	endtask

	task wrap_up;
		$display("errors %0d, comparisons %0d", err_count, checked);
		if (err_count == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ==========================================================
	// Tests
	initial
	begin
		#200000;
		err_count++;
		wrap_up();
	end

	initial
	begin
		foreach (img[i]) img[i] = 8'h00;
		img[0] = 8'ha5;
		img[1] = 8'h3c;
		img[2] = 8'h0f;
		img[3] = 8'hf0;
		img[4] = 8'h1e;
		// Initial reset: five rising edges low
		repeat (4) @(posedge mclk);
		#1 chk_held();
		@(posedge mclk);
		reset_n <= 1'b1;
		settle();
		foreach (img[i]) wr(13'(`ROL_CFG_BASE + i), img[i]);
		wr(13'h0123, 8'h5a);
		wr(13'h0fff, 8'hc3);
		wr(`ROL_STATUS_ADDR, 8'hff);
		pulse(1'b0);
		chk(pull_up_en, 16'h3ca5);
		chk(pull_down_en, 16'hf00f);
		chk({11'h0, clk_mon_reset_en, ext_clk_on_out_pin, wdt_hardlock, osc_cap_sel},
			16'h001e);
		rd(13'h0123, rdv);
		chk({8'h0, rdv}, 16'h5a);
		rd(13'h0fff, rdv);
		chk({8'h0, rdv}, 16'hc3);
		rd(`ROL_STATUS_ADDR, rdv);
		chk({8'h0, rdv}, 16'h01);
		rd(13'h1021, rdv);
		chk({8'h0, rdv}, 16'h00);
		// Cleared byte must vanish after reload, not be OR-ed in
		wr(`ROL_CFG_BASE, 8'h00);
		wr(13'h101f, 8'h01);
		pulse(1'b1);
		chk(pull_up_en, 16'h3c00);
		rd(13'h0123, rdv);
		chk({8'h0, rdv}, 16'h00);
		rd(`ROL_STATUS_ADDR, rdv);
		chk({8'h0, rdv}, 16'h03);
		rd(13'h1004, rdv);
		chk({8'h0, rdv}, 16'h1e);
		wrap_up();
	end
endmodule // rol_loader_tb

/* design/rol_loader.sv */
// Reset-time option loader: non-volatile store, option download, pin gating.
// Assumes one clock, registers written over a plain strobe port.
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`include "rol_params.svh"

module rol_loader
	import rol_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        reset_n,
	input  wire logic        brownout_n,
	input  wire logic [12:0] reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	output logic      [15:0] pull_up_en,
	output logic      [15:0] pull_down_en,
	output logic      [1:0]  osc_cap_sel,
	output logic             wdt_hardlock,
	output logic             ext_clk_on_out_pin,
	output logic             clk_mon_reset_en,
	output logic             port_force_input,
	output logic             options_valid
);

	// ==========================================================
	// Reset release and brown-out synchroniser
	logic       rst_s1_reg;
	logic       rst_n_int;
	logic [2:0] bor_sync_reg;
	logic       bor_low_reg;
	wire        bor_agree = (bor_sync_reg[1] == bor_sync_reg[2]);

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rst_s1_reg <= 1'b0;
			rst_n_int  <= 1'b0;
		end
		else
		begin
			rst_s1_reg <= 1'b1;
			rst_n_int  <= rst_s1_reg;
		end
	end

	always_ff @(posedge mclk or negedge rst_n_int)
	begin
		if (!rst_n_int)
		begin
			bor_sync_reg <= 3'h7;
			bor_low_reg  <= 1'b0;
		end
		else
		begin
			bor_sync_reg <= {bor_sync_reg[1:0], brownout_n};
			if (bor_agree)
				bor_low_reg <= ~bor_sync_reg[2];
		end
	end

	// ==========================================================
	// Non-volatile store: program bytes then option area
	// No reset on purpose: contents survive every reset
	logic [7:0] area_mem [0:`ROL_AREA_BYTES-1];
	wire        addr_in_area = (reg_addr < 13'(`ROL_AREA_BYTES));
	wire        addr_in_prog = (reg_addr < 13'(`ROL_PROG_BYTES));
	wire        wr_area      = reg_wr && addr_in_area;

	always_ff @(posedge mclk)
	begin
		if (wr_area)
			area_mem[reg_addr] <= reg_wdata;
	end

	// ==========================================================
	// Download sequencer
	rol_state_t                   state_reg;
	rol_state_t                   state_next;
	logic [7:0]                   bit_cnt_reg;
	logic [`ROL_CFG_BITS-1:0]     cfg_shift_reg;
	wire  [12:0]                  load_byte_addr = `ROL_CFG_BASE + {8'h00, bit_cnt_reg[7:3]};
	wire  [7:0]                   load_byte      = area_mem[load_byte_addr];
	wire                          load_bit       = load_byte[bit_cnt_reg[2:0]];

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			ST_CLEAR: state_next = ST_LOAD;
			ST_LOAD:  if (bit_cnt_reg == `ROL_LAST_BIT) state_next = ST_DONE;
			ST_DONE:  state_next = ST_DONE;
			default:  state_next = ST_CLEAR;
		endcase
		// Brown-out holds the loader at the start
		if (bor_low_reg)
			state_next = ST_CLEAR;
	end

	always_ff @(posedge mclk or negedge rst_n_int)
	begin
		if (!rst_n_int)
		begin
			state_reg     <= ST_CLEAR;
			bit_cnt_reg   <= 8'h00;
			cfg_shift_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
			if (state_reg == ST_CLEAR)
			begin
				bit_cnt_reg   <= 8'h00;
				cfg_shift_reg <= '0;
			end
			else if (state_reg == ST_LOAD)
			begin
				bit_cnt_reg   <= bit_cnt_reg + 8'h01;
				cfg_shift_reg <= {load_bit, cfg_shift_reg[`ROL_CFG_BITS-1:1]};
			end
		end
	end

	// ==========================================================
	// Option outputs, gated until the image is complete
	wire ld_done  = (state_reg == ST_DONE);
	wire lock_on  = cfg_shift_reg[`ROL_LOCK_BIT] || !ld_done;

	always_ff @(posedge mclk or negedge rst_n_int)
	begin
		if (!rst_n_int)
		begin
			pull_up_en         <= 16'h0000;
			pull_down_en       <= 16'h0000;
			osc_cap_sel        <= 2'h0;
			wdt_hardlock       <= 1'b0;
			ext_clk_on_out_pin <= 1'b0;
			clk_mon_reset_en   <= 1'b0;
			port_force_input   <= 1'b1;
			options_valid      <= 1'b0;
		end
		else
		begin
			pull_up_en   <= ld_done ? cfg_shift_reg[`ROL_PULLUP_LSB +: 16] : 16'h0000;
			pull_down_en <= ld_done ? cfg_shift_reg[`ROL_PULLDN_LSB +: 16] : 16'h0000;
			osc_cap_sel        <= ld_done ? cfg_shift_reg[`ROL_CAP_LSB +: 2] : 2'h0;
			wdt_hardlock       <= ld_done && cfg_shift_reg[`ROL_HARDLOCK_BIT];
			ext_clk_on_out_pin <= ld_done && cfg_shift_reg[`ROL_EXTOUT_BIT];
			clk_mon_reset_en   <= ld_done && cfg_shift_reg[`ROL_CLKMON_BIT];
			port_force_input   <= !ld_done;
			options_valid      <= ld_done;
		end
	end

	// ==========================================================
	// Register read port, data one cycle after the strobe
	wire [7:0] status_byte = {6'h00, lock_on, ld_done};
	wire [7:0] rd_mux =
		(reg_addr == `ROL_STATUS_ADDR)  ? status_byte :
		(addr_in_prog && lock_on)       ? 8'h00 :
		addr_in_area                    ? area_mem[reg_addr] : 8'h00;

	always_ff @(posedge mclk or negedge rst_n_int)
	begin
		if (!rst_n_int)
			reg_rdata <= 8'h00;
		else if (reg_rd)
			reg_rdata <= rd_mux;
	end

	// ==========================================================
	// Checks
	chk_clear_empties: assert property (@(posedge mclk) disable iff (!rst_n_int)
		state_reg == ST_CLEAR |=> cfg_shift_reg == '0)
		else $error("shift register not cleared");
	// Split by bit value so a never-programmed store byte does not trip the check
	chk_shift_takes_one: assert property (@(posedge mclk) disable iff (!rst_n_int)
		state_reg == ST_LOAD && load_bit |=> cfg_shift_reg[255])
		else $error("download one bit lost");
	chk_shift_takes_zero: assert property (@(posedge mclk) disable iff (!rst_n_int)
		state_reg == ST_LOAD && !load_bit |=> !cfg_shift_reg[255])
		else $error("download zero bit lost");
	chk_load_length: assert property (@(posedge mclk) disable iff (!rst_n_int)
		$rose(state_reg == ST_LOAD) |-> (state_reg == ST_LOAD || bor_low_reg)[*8])
		else $error("download ended early");
	chk_valid_after_last: assert property (@(posedge mclk) disable iff (!rst_n_int)
		state_reg == ST_LOAD && bit_cnt_reg == 8'hff && !bor_low_reg
		|=> ld_done ##1 options_valid)
		else $error("valid not raised after last bit");
	chk_pulls_gated: assert property (@(posedge mclk) disable iff (!rst_n_int)
		!options_valid |-> pull_up_en == 16'h0000 && pull_down_en == 16'h0000 && port_force_input)
		else $error("pull enabled before download done");
	chk_bor_restart: assert property (@(posedge mclk) disable iff (!rst_n_int)
		bor_low_reg |=> state_reg == ST_CLEAR ##1 !options_valid)
		else $error("brown-out did not restart download");
	chk_lock_refuse: assert property (@(posedge mclk) disable iff (!rst_n_int)
		reg_rd && addr_in_prog && lock_on |=> reg_rdata == 8'h00)
		else $error("protected program byte read out");
	chk_store_write: assert property (@(posedge mclk) disable iff (!rst_n_int)
		wr_area |=> area_mem[$past(reg_addr)] == $past(reg_wdata))
		else $error("store write lost");
	chk_clear_counter: assert property (@(posedge mclk) disable iff (!rst_n_int)
		state_reg == ST_CLEAR |=> bit_cnt_reg == 8'h00)
		else $error("bit counter not cleared");
	chk_force_until_done: assert property (@(posedge mclk) disable iff (!rst_n_int)
		state_reg != ST_DONE |=> port_force_input)
		else $error("ports released before download done");
	chk_valid_needs_done: assert property (@(posedge mclk) disable iff (!rst_n_int)
		!ld_done |=> !options_valid)
		else $error("options valid without done");
	chk_done_holds: assert property (@(posedge mclk) disable iff (!rst_n_int)
		ld_done && !bor_low_reg |=> ld_done)
		else $error("done dropped without brown-out");
	chk_options_gated: assert property (@(posedge mclk) disable iff (!rst_n_int)
		!options_valid |-> !wdt_hardlock && !ext_clk_on_out_pin && !clk_mon_reset_en
			&& osc_cap_sel == 2'h0)
		else $error("option active before download done");
	chk_status_done: assert property (@(posedge mclk) disable iff (!rst_n_int)
		reg_rd && reg_addr == `ROL_STATUS_ADDR
		|=> reg_rdata[`ROL_ST_DONE_BIT] == $past(ld_done))
		else $error("status done bit wrong");
	chk_bor_filter: assert property (@(posedge mclk) disable iff (!rst_n_int)
		$changed(bor_low_reg) |-> $past(bor_sync_reg[1]) == $past(bor_sync_reg[2]))
		else $error("brown-out taken before flops agree");

endmodule // rol_loader

/* design/rol_params.svh */
// Constants of the reset-time option loader: map, field positions, counts.
// Assumes one 50 MHz clock; included by the loader and the bench.
//
// Behaviour
// - 32-byte option area apart from program store
// - Area encodes pulls, capacitor, hardlock, clock options
// - Each reset downloads area into shift register
// - Power-on or brown-out: clear, then reload
// - Ports input, pulls off until download done
// - Program store holds 4096 bytes
// - Read-protect bit refuses program store read-out
`ifndef ROL_PARAMS_SVH
`define ROL_PARAMS_SVH

// ==========================================================
// Sizes
`define ROL_PROG_BYTES   4096
`define ROL_CFG_BYTES    32
`define ROL_BLOCK_BYTES  16
`define ROL_BLOCK_COUNT  258
`define ROL_AREA_BYTES   (`ROL_BLOCK_COUNT * `ROL_BLOCK_BYTES)
`define ROL_CFG_BITS     256
`define ROL_LAST_BIT     8'hff

// ==========================================================
// Register port map (byte addresses, 13-bit)
`define ROL_ADDR_W       13
`define ROL_CFG_BASE     13'h1000
`define ROL_STATUS_ADDR  13'h1020

// ==========================================================
// Option bit positions inside the downloaded 256-bit image
`define ROL_PULLUP_LSB   0
`define ROL_PULLDN_LSB   16
`define ROL_CAP_LSB      32
`define ROL_HARDLOCK_BIT 34
`define ROL_EXTOUT_BIT   35
`define ROL_CLKMON_BIT   36
`define ROL_LOCK_BIT     248

// ==========================================================
// Status register bits
`define ROL_ST_DONE_BIT  0
`define ROL_ST_LOCK_BIT  1

`endif

/* design/rol_pkg.sv */
// Types of the reset-time option loader.
// Assumes rol_params.svh is on the include path.
package rol_pkg;
	typedef enum logic [1:0]
	{
		ST_CLEAR = 2'b00,
		ST_LOAD  = 2'b01,
		ST_DONE  = 2'b10
	} rol_state_t;
endpackage
